// ==== src/asme_events.v ====
`timescale 1ns/10ps
// Functional notes
// - Shock detection uses only axes whose shock enable bit is set.
// - Shock threshold step is 7.81, 15.63, 31.25 or 62.5 mg by range.
// - Shock hysteresis step is 125, 250, 500 or 1000 mg by range.
// - Shock sets when any enabled axis exceeds threshold for the duration.
// - Shock clears when all enabled axes stay below threshold minus hysteresis.
// - Current shock state is readable as a status bit.
// - Shock duration is (value plus one) times 2 ms.
// - Immediate clear conflicts with filtered release; filtered release is used.
// - One-hot axis bits record which axis triggered the shock.
// - Axis bits clear together with the shock status.
// - Sign bit holds the triggering acceleration sign, one for negative.
// - Slow-motion sets after N slopes above, clears after N below.
// - No-motion fires when all selected slopes stay below threshold for delay.
// - In no-motion mode bits 5:0 of the duration field are a delay code.
// - Mode select one chooses no-motion, zero chooses slow-motion.
// - Only slope-enabled axes are monitored in both modes.
// - Slope threshold step is 3.91, 7.81, 15.6 or 31.3 mg by range.
// - Slopes use samples spaced one over twice the bandwidth.
// - No-motion codes 0 to 15 give code plus one seconds.
// - Codes 16-21 give 40 s plus 8 s steps; 32-63 give 88 s plus steps.
// - Writing 0xB6 to soft reset restores all configuration defaults.
`include "asme_defines.vh"

module asme_events #(
  parameter integer SHOCK_STEP_CYC = `ASME_SHOCK_STEP_CYC,
  parameter integer TICK_CYC       = `ASME_TICK_CYC
) (
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire        sample_valid,
  input  wire [11:0] acc_x,
  input  wire [11:0] acc_y,
  input  wire [11:0] acc_z,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [5:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg         shock_event,
  output reg         slope_event
);

  // Samples are 12-bit two's complement; 1 LSB equals half of a slope step.
  // Range scales the sample weight and every step alike, so LSB factors are fixed.
  reg [7:0]  shock_dur_q;
  reg [7:0]  shock_th_q;
  reg [7:0]  slope_dur_q;
  reg [7:0]  slope_th_q;
  reg [1:0]  shock_hy_q;
  reg [2:0]  shock_en_q;
  reg [3:0]  slope_cfg_q;
  reg [1:0]  range_q;
  reg        shock_q;
  reg [2:0]  shock_axis_q;
  reg        shock_sign_q;
  reg        slope_q;
  reg [1:0]  slow_cnt_q;
  reg [8:0]  shock_cnt_q;
  reg [31:0] step_div_q;
  reg [31:0] tick_div_q;
  reg [8:0]  nomo_sec_q;

  wire [35:0] cur = {acc_z, acc_y, acc_x};
  wire        step_pulse = (step_div_q == SHOCK_STEP_CYC - 1);
  wire        tick_pulse = (tick_div_q == TICK_CYC - 1);

  function [11:0] abs12;
    input [11:0] v;
    begin
      abs12 = v[11] ? (~v + 12'h001) : v;
    end
  endfunction

  // No-motion delay in seconds from the code.
  function [8:0] nomo_secs;
    input [5:0] c;
    begin
      if (c < 6'd16) begin
        nomo_secs = {3'b000, c} + 9'd1;
      end else if (c < 6'd22) begin
        nomo_secs = 9'd40 + {c - 6'd16, 3'b000};
      end else if (c < 6'd32) begin
        nomo_secs = 9'd80;
      end else begin
        nomo_secs = 9'd88 + {c - 6'd32, 3'b000};
      end
    end
  endfunction

  // Shock threshold step is four sample LSB.
  function [12:0] shock_th_lsb;
    input [7:0] th;
    begin
      shock_th_lsb = {3'b000, th, 2'b00};
    end
  endfunction

  // Shock hysteresis step is sixty-four sample LSB.
  function [12:0] shock_hy_lsb;
    input [1:0] hy;
    begin
      shock_hy_lsb = {5'b00000, hy, 6'b000000};
    end
  endfunction

  // Slope threshold step is two sample LSB.
  function [12:0] slope_th_lsb;
    input [7:0] th;
    begin
      slope_th_lsb = {4'b0000, th, 1'b0};
    end
  endfunction

  wire [12:0] th_lsb  = shock_th_lsb(shock_th_q);
  wire [12:0] hy_lsb  = shock_hy_lsb(shock_hy_q);
  wire [12:0] sl_lsb  = slope_th_lsb(slope_th_q);
  wire [12:0] rel_lsb = (th_lsb > hy_lsb) ? (th_lsb - hy_lsb) : 13'h0000;

  wire [2:0]  above;
  wire [2:0]  below;
  wire [2:0]  slope_hi;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_axis
      reg  [11:0] prev_q;
      wire [11:0] mag = abs12(cur[12*g +: 12]);
      wire [12:0] diff = {cur[12*g+11], cur[12*g +: 12]}
                       - {prev_q[11], prev_q};
      wire [12:0] dabs = diff[12] ? (~diff + 13'h0001) : diff;
      // Previous sample of this axis, taken on every sample strobe.
      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          prev_q <= 12'h000;
        end else if (sample_valid) begin
          prev_q <= cur[12*g +: 12];
        end
      end
      assign above[g]    = shock_en_q[g] && ({1'b0, mag} > th_lsb);
      assign below[g]    = !shock_en_q[g] || ({1'b0, mag} < rel_lsb);
      assign slope_hi[g] = slope_cfg_q[g] && (dabs > sl_lsb);
    end
  endgenerate

  wire any_above = |above;
  wire all_below = &below;
  wire any_slope = |slope_hi;
  wire nomo_mode = slope_cfg_q[`ASME_SLOPE_SEL_BIT];
  wire soft_rst  = reg_wr && (reg_addr == `ASME_ADDR_SOFT_RESET)
                && (reg_wdata == `ASME_SOFT_RESET_KEY);
  wire [2:0] first_axis = above[0] ? 3'b001 : (above[1] ? 3'b010 : 3'b100);
  wire       first_sign = above[0] ? acc_x[11] : (above[1] ? acc_y[11] : acc_z[11]);
  wire       shock_cond = shock_q ? all_below : any_above;

  // Register file and soft reset.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      shock_dur_q <= `ASME_RST_SHOCK_DUR;
      shock_th_q  <= `ASME_RST_SHOCK_TH;
      slope_dur_q <= `ASME_RST_SLOPE_DUR;
      slope_th_q  <= `ASME_RST_SLOPE_TH;
      shock_hy_q  <= `ASME_RST_SHOCK_HYST;
      shock_en_q  <= `ASME_RST_SHOCK_EN;
      slope_cfg_q <= `ASME_RST_SLOPE_CFG;
      range_q     <= `ASME_RST_RANGE;
    end else if (soft_rst) begin
      shock_dur_q <= `ASME_RST_SHOCK_DUR;
      shock_th_q  <= `ASME_RST_SHOCK_TH;
      slope_dur_q <= `ASME_RST_SLOPE_DUR;
      slope_th_q  <= `ASME_RST_SLOPE_TH;
      shock_hy_q  <= `ASME_RST_SHOCK_HYST;
      shock_en_q  <= `ASME_RST_SHOCK_EN;
      slope_cfg_q <= `ASME_RST_SLOPE_CFG;
      range_q     <= `ASME_RST_RANGE;
    end else if (reg_wr) begin
      case (reg_addr)
        `ASME_ADDR_SHOCK_DUR:  shock_dur_q <= reg_wdata;
        `ASME_ADDR_SHOCK_TH:   shock_th_q  <= reg_wdata;
        `ASME_ADDR_SLOPE_DUR:  slope_dur_q <= reg_wdata;
        `ASME_ADDR_SLOPE_TH:   slope_th_q  <= reg_wdata;
        `ASME_ADDR_SHOCK_HYST: shock_hy_q  <= reg_wdata[`ASME_HYST_LSB +: 2];
        `ASME_ADDR_SHOCK_EN:   shock_en_q  <= reg_wdata[`ASME_SHOCK_EN_LSB +: 3];
        `ASME_ADDR_SLOPE_CFG:  slope_cfg_q <= reg_wdata[`ASME_SLOPE_EN_LSB +: 4];
        `ASME_ADDR_RANGE:      range_q     <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // Read data is registered one cycle after the read strobe.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ASME_ADDR_SHOCK_DUR:   reg_rdata <= shock_dur_q;
        `ASME_ADDR_SHOCK_TH:    reg_rdata <= shock_th_q;
        `ASME_ADDR_SLOPE_DUR:   reg_rdata <= slope_dur_q;
        `ASME_ADDR_SLOPE_TH:    reg_rdata <= slope_th_q;
        `ASME_ADDR_SHOCK_HYST:  reg_rdata <= {shock_hy_q, 6'h00};
        `ASME_ADDR_SHOCK_EN:    reg_rdata <= {5'h00, shock_en_q};
        `ASME_ADDR_SLOPE_CFG:   reg_rdata <= {4'h0, slope_cfg_q};
        `ASME_ADDR_RANGE:       reg_rdata <= {6'h00, range_q};
        `ASME_ADDR_EVT_STATUS:  reg_rdata <= {4'h0, slope_q, 1'b0, shock_q, 1'b0};
        `ASME_ADDR_SHOCK_AXIS:  reg_rdata <= {4'h0, shock_sign_q, shock_axis_q};
        default:                reg_rdata <= 8'h00;
      endcase
    end
  end

  // Dividers for the 2 ms step and the 1 s tick.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      step_div_q <= 32'h0000_0000;
      tick_div_q <= 32'h0000_0000;
    end else begin
      step_div_q <= step_pulse ? 32'h0000_0000 : step_div_q + 32'h0000_0001;
      tick_div_q <= tick_pulse ? 32'h0000_0000 : tick_div_q + 32'h0000_0001;
    end
  end

  // Shock detector with duration filter on both set and release.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      shock_q      <= 1'b0;
      shock_axis_q <= 3'b000;
      shock_sign_q <= 1'b0;
      shock_cnt_q  <= 9'h000;
      shock_event  <= 1'b0;
    end else if (soft_rst) begin
      shock_q      <= 1'b0;
      shock_axis_q <= 3'b000;
      shock_sign_q <= 1'b0;
      shock_cnt_q  <= 9'h000;
      shock_event  <= 1'b0;
    end else begin
      if (!shock_cond) begin
        shock_cnt_q <= 9'h000;
      end else if (step_pulse) begin
        if (shock_cnt_q >= {1'b0, shock_dur_q}) begin
          shock_cnt_q <= 9'h000;
          shock_q     <= !shock_q;
          shock_event <= !shock_q;
          if (!shock_q) begin
            shock_axis_q <= first_axis;
            shock_sign_q <= first_sign;
          end else begin
            shock_axis_q <= 3'b000;
            shock_sign_q <= 1'b0;
          end
        end else begin
          shock_cnt_q <= shock_cnt_q + 9'h001;
        end
      end
    end
  end

  // Slope engine in slow-motion or no-motion mode.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      slope_q     <= 1'b0;
      slow_cnt_q  <= 2'b00;
      nomo_sec_q  <= 9'h000;
      slope_event <= 1'b0;
    end else if (soft_rst) begin
      slope_q     <= 1'b0;
      slow_cnt_q  <= 2'b00;
      nomo_sec_q  <= 9'h000;
      slope_event <= 1'b0;
    end else if (nomo_mode) begin
      slow_cnt_q <= 2'b00;
      if (sample_valid && any_slope) begin
        nomo_sec_q  <= 9'h000;
        slope_q     <= 1'b0;
        slope_event <= 1'b0;
      end else if (tick_pulse && !slope_q) begin
        if (nomo_sec_q + 9'h001 >= nomo_secs(slope_dur_q[5:0])) begin
          slope_q     <= 1'b1;
          slope_event <= 1'b1;
        end else begin
          nomo_sec_q <= nomo_sec_q + 9'h001;
        end
      end
    end else if (sample_valid) begin
      nomo_sec_q <= 9'h000;
      if (any_slope != slope_q) begin
        if (slow_cnt_q == slope_dur_q[1:0]) begin
          slow_cnt_q  <= 2'b00;
          slope_q     <= any_slope;
          slope_event <= any_slope;
        end else begin
          slow_cnt_q <= slow_cnt_q + 2'b01;
        end
      end else begin
        slow_cnt_q <= 2'b00;
      end
    end
  end

endmodule // asme_events

// ==== shared/asme_defines.vh ====
`ifndef ASME_DEFINES_VH
`define ASME_DEFINES_VH

// Register addresses.
`define ASME_ADDR_SOFT_RESET    6'h14
`define ASME_ADDR_SHOCK_DUR     6'h25
`define ASME_ADDR_SHOCK_TH      6'h26
`define ASME_ADDR_SLOPE_DUR     6'h27
`define ASME_ADDR_SLOPE_TH      6'h29
`define ASME_ADDR_SHOCK_HYST    6'h24
`define ASME_ADDR_SHOCK_EN      6'h17
`define ASME_ADDR_SLOPE_CFG     6'h18
`define ASME_ADDR_RANGE         6'h0F
`define ASME_ADDR_EVT_STATUS    6'h09
`define ASME_ADDR_SHOCK_AXIS    6'h0C

// Field positions.
`define ASME_SHOCK_EN_LSB       0
`define ASME_SLOPE_EN_LSB       0
`define ASME_SLOPE_SEL_BIT      3
`define ASME_HYST_LSB           6
`define ASME_STAT_SHOCK_BIT     1
`define ASME_STAT_SLOPE_BIT     3
`define ASME_AXIS_SIGN_BIT      3

// Reset values.
`define ASME_RST_SHOCK_DUR      8'h0F
`define ASME_RST_SHOCK_TH       8'hC0
`define ASME_RST_SLOPE_DUR      8'h00
`define ASME_RST_SLOPE_TH       8'h14
`define ASME_RST_SHOCK_HYST     2'h2
`define ASME_RST_SHOCK_EN       3'h0
`define ASME_RST_SLOPE_CFG      4'h0
`define ASME_RST_RANGE          2'h0
`define ASME_SOFT_RESET_KEY     8'hB6

// Timing: clock rate in Hz, shock step in us, no-motion tick in s.
`define ASME_CLK_HZ             200000000
`define ASME_SHOCK_STEP_US      2000
`define ASME_TICK_S             1
`define ASME_SHOCK_STEP_CYC     (`ASME_CLK_HZ / 1000000 * `ASME_SHOCK_STEP_US)
`define ASME_TICK_CYC           (`ASME_CLK_HZ * `ASME_TICK_S)

`endif

// ==== dv/asme_events_chk.sv ====
`timescale 1ns/10ps
`include "asme_defines.vh"
module asme_events_chk #(
  parameter integer SHOCK_STEP_CYC = 10
) (
  input wire        clk_sys,
  input wire        arst_n,
  input wire        sample_valid,
  input wire [11:0] acc_x,
  input wire [11:0] acc_y,
  input wire [11:0] acc_z,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [5:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_rdata,
  input wire        shock_event,
  input wire        slope_event
);
  reg  [31:0] up_q;
  wire        key_w = reg_wr && reg_addr == 6'h14 && reg_wdata == 8'hB6;
  // Counts cycles since reset release, saturating.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      up_q <= 32'h0000_0000;
    else if (up_q != 32'hFFFF_FFFF)
      up_q <= up_q + 32'h0000_0001;
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  soft_read_a: assert property (reg_rd && reg_addr == 6'h14 |=> reg_rdata == 8'h00)
    else $error("soft reset register did not read zero");
  soft_clear_a: assert property (key_w |-> ##2 !shock_event && !slope_event)
    else $error("events survived soft reset");
  soft_dflt_a: assert property (key_w ##1 (reg_rd && reg_addr == 6'h26) |=>
    reg_rdata == `ASME_RST_SHOCK_TH) else $error("threshold default not restored");
  status_bit_a: assert property (reg_rd && reg_addr == 6'h09 |=>
    reg_rdata[1] == $past(shock_event) && reg_rdata[3] == $past(slope_event))
    else $error("status bits differ from event outputs");
  axis_clear_a: assert property (reg_rd && reg_addr == 6'h0C && !shock_event |=>
    reg_rdata[3:0] == 4'h0) else $error("axis bits set without shock");
  axis_onehot_a: assert property (reg_rd && reg_addr == 6'h0C && shock_event |=>
    $onehot(reg_rdata[2:0])) else $error("axis bits not one-hot");
  shock_min_a: assert property ($rose(shock_event) |-> up_q >= SHOCK_STEP_CYC - 1)
    else $error("shock raised before one duration step");
  thr_echo_a: assert property ((reg_wr && reg_addr == 6'h26) ##1 (!reg_wr && !reg_rd) ##1
    (reg_rd && !reg_wr && reg_addr == 6'h26) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("threshold readback wrong");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  shock_cov: cover property ($rose(shock_event));
  slope_cov: cover property ($rose(slope_event));
  soft_cov: cover property (key_w);
endmodule // asme_events_chk

bind asme_events asme_events_chk #(.SHOCK_STEP_CYC(SHOCK_STEP_CYC)) u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .sample_valid(sample_valid), .acc_x(acc_x),
  .acc_y(acc_y), .acc_z(acc_z), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .shock_event(shock_event),
  .slope_event(slope_event));

// ==== dv/asme_host.sv ====
`timescale 1ns/10ps
module asme_host #(
  parameter integer WAKE_CYC = 20
) (
  input  wire       clk_sys,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [5:0] reg_addr,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end
  // Strobes for one cycle, then scrambles the released address and data.
  task xfer(input wr, input [5:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, d};
      @(posedge clk_sys);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b00, ~a, ~d};
    end
  endtask
  task rd(input [5:0] a, output [7:0] d);
    begin
      xfer(1'b0, a, 8'h00);
      @(posedge clk_sys);
      #1;
      d = reg_rdata;
    end
  endtask
  task soft_reset;
    begin
      xfer(1'b1, 6'h14, 8'hB6);
      repeat (WAKE_CYC) @(posedge clk_sys);
    end
  endtask
endmodule // asme_host

// ==== dv/asme_events_tb.sv ====
`timescale 1ns/10ps
module asme_events_tb;
  reg         clk_sys = 1'b0;
  reg         arst_n = 1'b0;
  reg         sample_valid = 1'b0;
  reg  [11:0] acc_x = 12'h000;
  reg  [11:0] acc_y = 12'h000;
  reg  [11:0] acc_z = 12'h000;
  wire        reg_wr, reg_rd, shock_event, slope_event;
  wire [5:0]  reg_addr;
  wire [7:0]  reg_wdata, reg_rdata;
  reg  [31:0] rng_q = 32'h0000_9cc9;
  reg  [7:0]  rd_v;
  integer     err_total = 0, compares = 0, cyc = 0, i;
  always #2.5 clk_sys = ~clk_sys;
  asme_events #(.SHOCK_STEP_CYC(10), .TICK_CYC(50)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .sample_valid(sample_valid), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .shock_event(shock_event), .slope_event(slope_event));
  asme_host host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  function [31:0] xs(input [31:0] s);
    begin
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      xs = s ^ (s << 5);
    end
  endfunction
  function [7:0] axis_exp(input [2:0] ax, input neg);
    axis_exp = {4'h0, neg, ax};
  endfunction
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task rdchk(input [5:0] a, input [7:0] exp);
    begin
      host.rd(a, rd_v);
      chk("register", rd_v, exp);
    end
  endtask
  task smp(input [11:0] x);
    begin
      @(posedge clk_sys);
      acc_x <= x;
      sample_valid <= 1'b1;
      @(posedge clk_sys);
      sample_valid <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    rdchk(6'h26, 8'hC0);
    rdchk(6'h3F, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      rng_q = xs(rng_q);
      host.xfer(1'b1, (i == 3) ? 6'h29 : 6'h25 + i, rng_q[7:0]);
      rdchk((i == 3) ? 6'h29 : 6'h25 + i, rng_q[7:0]);
    end
    host.xfer(1'b1, 6'h0F, 8'h00);
    host.xfer(1'b1, 6'h26, 8'h20);
    host.xfer(1'b1, 6'h24, 8'h40);
    host.xfer(1'b1, 6'h25, 8'h01);
    host.xfer(1'b1, 6'h17, 8'h01);
    acc_y <= 12'h7D0;
    acc_z <= rng_q[11:0];
    acc_x <= 12'h064;
    repeat (60) @(posedge clk_sys);
    chk("shock", {7'h00, shock_event}, 8'h00);
    acc_x <= 12'hF38;
    repeat (5) @(posedge clk_sys);
    chk("shock", {7'h00, shock_event}, 8'h00);
    repeat (55) @(posedge clk_sys);
    chk("shock", {7'h00, shock_event}, 8'h01);
    rdchk(6'h0C, axis_exp(3'b001, 1'b1));
    rdchk(6'h09, 8'h02);
    acc_x <= 12'h064;
    repeat (60) @(posedge clk_sys);
    chk("shock", {7'h00, shock_event}, 8'h01);
    acc_x <= 12'h00A;
    repeat (60) @(posedge clk_sys);
    chk("shock", {7'h00, shock_event}, 8'h00);
    rdchk(6'h0C, 8'h00);
    host.xfer(1'b1, 6'h29, 8'h10);
    host.xfer(1'b1, 6'h27, 8'h01);
    host.xfer(1'b1, 6'h18, 8'h01);
    for (i = 0; i < 4; i = i + 1)
      smp(i[0] ? 12'h064 : 12'h000);
    chk("slope", {7'h00, slope_event}, 8'h01);
    for (i = 0; i < 4; i = i + 1)
      smp(12'h000);
    chk("slope", {7'h00, slope_event}, 8'h00);
    host.xfer(1'b1, 6'h27, 8'h10);
    host.xfer(1'b1, 6'h18, 8'h09);
    repeat (1500) @(posedge clk_sys);
    chk("slope", {7'h00, slope_event}, 8'h00);
    repeat (700) @(posedge clk_sys);
    chk("slope", {7'h00, slope_event}, 8'h01);
    host.soft_reset;
    chk("slope", {7'h00, slope_event}, 8'h00);
    rdchk(6'h18, 8'h00);
    rdchk(6'h26, 8'hC0);
    tally_and_finish;
  end
endmodule // asme_events_tb
